// ### hdl/modem_host_mem.v
// Purpose: host interface memory of a synchronous modem, three banks
// Assumes: Avalon-MM slave, word addressed by byte address bits [7:2]
// Notes:   long times are parameters so simulation can shorten them
// Operation
// - baud irq enabled: irq low while baud data available is one
// - sample irq enabled: irq low while sample data available is one
// - sample data available sets when receiver writes new data
// - reading bank data register zero clears that bank's data available
// - receiver setup bit set by host, cleared once config applied
// - transmitter setup bit set by host, cleared once config applied
// - receiver parallel mode delivers data via receiver data register
// - transmit while register or pin request-to-send, then turn-off
// - short echo bit selects 30 ms tone, otherwise 185 ms
// - buffer available clears on data write, sets when transmitter empties it
// - transmitter irq active bit one while it pulls irq low
// - transmit irq enabled: irq low while buffer available is one
// - train-on-data retrains after 0.5 s of poor quality
// - transmit parallel mode takes data from transmit data register
// - host waits 10 ms after reset release before configuring
// - reset defaults: 9600, half baud, standard tone, serial, disabled
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.

`timescale 1ns/1ps
`include "modem_host_consts.vh"
module modem_host_mem #(
  parameter ECHO_SHORT_CYC = `ECHO_SHORT_MS * `CYC_PER_MS,
  parameter ECHO_LONG_CYC  = `ECHO_LONG_MS * `CYC_PER_MS,
  parameter TOD_CYC        = `TOD_MS * `CYC_PER_MS,
  parameter READY_CYC      = `READY_MS * `CYC_PER_MS,
  parameter TURNOFF_CYC    = `TURNOFF_MS * `CYC_PER_MS,
  parameter BIT_CYC        = 20833
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // avalon-mm slave
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  // modem core side
  input  wire        rx_word_valid_i,
  input  wire [15:0] rx_word_i,
  input  wire        baud_word_valid_i,
  input  wire [15:0] baud_word_i,
  input  wire        eq_quality_poor_i,
  input  wire        rts_pin_i,
  input  wire        txd_pin_i,
  input  wire        ext_tx_clk_i,
  // outputs
  output reg         irq_n_o,
  output reg         tx_active_o,
  output reg         tx_bit_o,
  output reg         echo_tone_o,
  output reg         rxd_serial_o,
  output reg         retrain_o,
  output reg         ready_o,
  output reg  [7:0]  tx_cfg_o,
  output reg  [5:0]  rx_cfg_o
);
  localparam TS_IDLE = 2'h0;
  localparam TS_ECHO = 2'h1;
  localparam TS_DATA = 2'h2;
  localparam TS_OFF  = 2'h3;

  reg  [7:0]  tx_data_reg;
  reg  [7:0]  tx_cfg_reg;
  reg  [7:0]  tx_ctrl_reg;
  reg  [5:0]  rx_cfg_reg;
  reg         tod_reg;
  reg  [7:0]  rx_ctrl_reg;
  reg  [15:0] ysw_reg;
  reg  [15:0] ybw_reg;
  reg  [7:0]  acc_reg [0:3];
  reg         tx_buffer_avail_reg;
  reg         tx_irq_enable_reg;
  reg         tx_setup_strobe_reg;
  reg         sample_rx_data_avail_reg;
  reg         sample_rx_irq_enable_reg;
  reg         rx_setup_strobe_reg;
  reg         baud_rx_data_avail_reg;
  reg         baud_rx_irq_enable_reg;
  reg         ack_reg;
  reg  [1:0]  rts_sync_reg;
  reg  [1:0]  txd_sync_reg;
  reg  [1:0]  xclk_sync_reg;
  reg         xclk_last_reg;
  reg  [1:0]  tstate_reg;
  reg  [31:0] tcnt_reg;
  reg  [31:0] bitcnt_reg;
  reg  [2:0]  bitpos_reg;
  reg         byte_full_reg;
  reg  [7:0]  shift_reg;
  reg  [31:0] tod_cnt_reg;
  reg  [31:0] ready_cnt_reg;
  reg  [3:0]  rx_shift_cnt_reg;
  reg         tx_ia_reg;
  reg         rs_ia_reg;
  reg         rb_ia_reg;

  wire [1:0]  bank   = avs_address_i[7:6];
  wire [3:0]  index  = avs_address_i[5:2];
  wire        req    = (avs_read_i | avs_write_i) & ~ack_reg;
  wire        wr     = avs_write_i & req;
  wire        rd     = avs_read_i & req;
  wire [7:0]  wdat   = avs_writedata_i[7:0];
  wire        tx_ia  = tx_irq_enable_reg & tx_buffer_avail_reg;
  wire        rs_ia  = sample_rx_irq_enable_reg & sample_rx_data_avail_reg;
  wire        rb_ia  = baud_rx_irq_enable_reg & baud_rx_data_avail_reg;
  wire        rts    = tx_ctrl_reg[`CT_RTS_BIT] | rts_sync_reg[1];
  wire        xedge  = xclk_sync_reg[1] & ~xclk_last_reg;
  wire        tick   = tx_ctrl_reg[`CT_EXT_TX_CLOCK_SELECT_BIT] ? xedge :
                       (bitcnt_reg == BIT_CYC - 1);
  wire        parallel = tx_ctrl_reg[`CT_TX_PARALLEL_MODE_BIT];
  wire        sample_rd = rd && bank == `BANK_RXS && index == `REG_DATA0;
  wire        baud_rd   = rd && bank == `BANK_RXB && index == `REG_DATA0;
  wire        txd_wr    = wr && bank == `BANK_TX && index == `REG_DATA0;
  wire        drain     = parallel && tstate_reg == TS_DATA && tick && bitpos_reg == 3'h7;
  reg  [7:0]  rdata;
  reg  [1:0]  tstate_next;

  // register read mux
  always @* begin
    rdata = 8'h00;
    case (bank)
      `BANK_TX: begin
        case (index)
          `REG_CONFIG: rdata = tx_cfg_reg;
          `REG_CTRL:   rdata = tx_ctrl_reg;
          `REG_STATUS: rdata = {tx_ia_reg, 3'h0, tx_setup_strobe_reg,
                                tx_irq_enable_reg, 1'b0, tx_buffer_avail_reg};
          default:     rdata = 8'h00;
        endcase
      end
      `BANK_RXS: begin
        case (index)
          `REG_DATA0:  rdata = ysw_reg[7:0];
          `REG_DATA1:  rdata = ysw_reg[15:8];
          `REG_ACC_Y:  rdata = acc_reg[0];
          `REG_ACC_X:  rdata = acc_reg[1];
          `REG_CONFIG: rdata = {1'b0, tod_reg, rx_cfg_reg};
          `REG_CTRL:   rdata = rx_ctrl_reg;
          `REG_STATUS: rdata = {rs_ia_reg, 3'h0, rx_setup_strobe_reg,
                                sample_rx_irq_enable_reg, 1'b0, sample_rx_data_avail_reg};
          default:     rdata = 8'h00;
        endcase
      end
      `BANK_RXB: begin
        case (index)
          `REG_DATA0:  rdata = ybw_reg[7:0];
          `REG_DATA1:  rdata = ybw_reg[15:8];
          `REG_ACC_Y:  rdata = acc_reg[2];
          `REG_ACC_X:  rdata = acc_reg[3];
          `REG_STATUS: rdata = {rb_ia_reg, 4'h0, baud_rx_irq_enable_reg,
                                1'b0, baud_rx_data_avail_reg};
          default:     rdata = 8'h00;
        endcase
      end
      default: rdata = 8'h00;
    endcase
  end

  // transmitter sequencer
  always @* begin
    tstate_next = tstate_reg;
    case (tstate_reg)
      TS_IDLE: if (rts && ready_o) tstate_next = TS_ECHO;
      TS_ECHO: if (tcnt_reg == 32'h0) tstate_next = TS_DATA;
      TS_DATA: if (!rts) tstate_next = TS_OFF;
      TS_OFF:  if (rts) tstate_next = TS_DATA;
               else if (tcnt_reg == 32'h0) tstate_next = TS_IDLE;
      default: tstate_next = TS_IDLE;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_acc
      always @(posedge clk_i) begin
        if (sys_rst_i)
          acc_reg[g] <= 8'h00;
        else if (wr && bank == (g >= 2 ? `BANK_RXB : `BANK_RXS) &&
                 index == (g % 2 == 1 ? `REG_ACC_X : `REG_ACC_Y))
          acc_reg[g] <= wdat;
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o           <= 32'h0;
      avs_waitrequest_o        <= 1'b1;
      ack_reg                  <= 1'b0;
      tx_data_reg              <= 8'h00;
      tx_cfg_reg               <= `TX_CFG_RESET;
      tx_ctrl_reg              <= `TX_CTRL_RESET;
      rx_cfg_reg               <= `RX_CFG_RESET;
      tod_reg                  <= 1'b0;
      rx_ctrl_reg              <= `RX_CTRL_RESET;
      ysw_reg                  <= 16'h0;
      ybw_reg                  <= 16'h0;
      tx_buffer_avail_reg      <= 1'b1;
      tx_irq_enable_reg        <= 1'b0;
      tx_setup_strobe_reg      <= 1'b0;
      sample_rx_data_avail_reg <= 1'b0;
      sample_rx_irq_enable_reg <= 1'b0;
      rx_setup_strobe_reg      <= 1'b0;
      baud_rx_data_avail_reg   <= 1'b0;
      baud_rx_irq_enable_reg   <= 1'b0;
      rts_sync_reg             <= 2'h0;
      txd_sync_reg             <= 2'h3;
      xclk_sync_reg            <= 2'h0;
      xclk_last_reg            <= 1'b0;
      tstate_reg               <= TS_IDLE;
      tcnt_reg                 <= 32'h0;
      bitcnt_reg               <= 32'h0;
      bitpos_reg               <= 3'h0;
      byte_full_reg            <= 1'b0;
      shift_reg                <= 8'hff;
      tod_cnt_reg              <= 32'h0;
      ready_cnt_reg            <= 32'h0;
      rx_shift_cnt_reg         <= 4'h0;
      tx_ia_reg                <= 1'b0;
      rs_ia_reg                <= 1'b0;
      rb_ia_reg                <= 1'b0;
      irq_n_o                  <= 1'b1;
      tx_active_o              <= 1'b0;
      tx_bit_o                 <= 1'b1;
      echo_tone_o              <= 1'b0;
      rxd_serial_o             <= 1'b1;
      retrain_o                <= 1'b0;
      ready_o                  <= 1'b0;
      tx_cfg_o                 <= `TX_CFG_RESET;
      rx_cfg_o                 <= `RX_CFG_RESET;
    end else begin
      // bus: one wait cycle, answer on the second
      ack_reg           <= req;
      avs_waitrequest_o <= ~req;
      if (rd)
        avs_readdata_o <= {24'h0, rdata};

      // input synchronisers
      rts_sync_reg  <= {rts_sync_reg[0], rts_pin_i};
      txd_sync_reg  <= {txd_sync_reg[0], txd_pin_i};
      xclk_sync_reg <= {xclk_sync_reg[0], ext_tx_clk_i};
      xclk_last_reg <= xclk_sync_reg[1];

      // ready after reset release
      if (ready_cnt_reg == READY_CYC - 1)
        ready_o <= 1'b1;
      else
        ready_cnt_reg <= ready_cnt_reg + 32'h1;

      // host writes
      if (wr) begin
        case ({bank, index})
          {`BANK_TX, `REG_DATA0}:  tx_data_reg <= wdat;
          {`BANK_TX, `REG_CONFIG}: tx_cfg_reg <= wdat;
          {`BANK_TX, `REG_CTRL}:   tx_ctrl_reg <= wdat;
          {`BANK_RXS, `REG_CONFIG}: begin
            rx_cfg_reg <= wdat[5:0];
            tod_reg    <= wdat[`CF_TOD_BIT];
          end
          {`BANK_RXS, `REG_CTRL}:  rx_ctrl_reg <= wdat;
          default: ;
        endcase
      end

      // setup strobes: applied on the cycle after being set
      if (wr && bank == `BANK_TX && index == `REG_STATUS) begin
        tx_irq_enable_reg   <= wdat[`ST_IE_BIT];
        tx_setup_strobe_reg <= wdat[`ST_SETUP_BIT];
      end else if (tx_setup_strobe_reg) begin
        tx_cfg_o            <= tx_cfg_reg;
        tx_setup_strobe_reg <= 1'b0;
      end
      if (wr && bank == `BANK_RXS && index == `REG_STATUS) begin
        sample_rx_irq_enable_reg <= wdat[`ST_IE_BIT];
        rx_setup_strobe_reg      <= wdat[`ST_SETUP_BIT];
      end else if (rx_setup_strobe_reg) begin
        rx_cfg_o            <= rx_cfg_reg;
        rx_setup_strobe_reg <= 1'b0;
      end

      // baud interrupt enable
      if (wr && bank == `BANK_RXB && index == `REG_STATUS)
        baud_rx_irq_enable_reg <= wdat[`ST_IE_BIT];

      // data available flags, set wins over read clear
      if (rx_word_valid_i) begin
        ysw_reg                  <= rx_word_i;
        sample_rx_data_avail_reg <= 1'b1;
        rx_shift_cnt_reg         <= 4'h0;
      end else if (sample_rd)
        sample_rx_data_avail_reg <= 1'b0;
      if (baud_word_valid_i) begin
        ybw_reg                <= baud_word_i;
        baud_rx_data_avail_reg <= 1'b1;
      end else if (baud_rd)
        baud_rx_data_avail_reg <= 1'b0;

      // serial receive output, clocked from the latest word in serial mode
      if (!rx_ctrl_reg[`CR_RX_PARALLEL_MODE_BIT] && tick && rx_shift_cnt_reg != 4'h8) begin
        rxd_serial_o     <= ysw_reg[rx_shift_cnt_reg[2:0]];
        rx_shift_cnt_reg <= rx_shift_cnt_reg + 4'h1;
      end

      // buffer available, emptying wins over a new write
      if (drain)
        tx_buffer_avail_reg <= 1'b1;
      else if (txd_wr)
        tx_buffer_avail_reg <= 1'b0;

      // interrupt line
      irq_n_o <= ~(tx_ia | rs_ia | rb_ia);
      // per bank active bits, registered together with the line
      tx_ia_reg <= tx_ia;
      rs_ia_reg <= rs_ia;
      rb_ia_reg <= rb_ia;

      // transmit sequencer and bit timing
      tstate_reg <= tstate_next;
      bitcnt_reg <= (tick || tx_ctrl_reg[`CT_EXT_TX_CLOCK_SELECT_BIT]) ? 32'h0 : bitcnt_reg + 32'h1;
      if (tstate_reg == TS_IDLE && tstate_next == TS_ECHO)
        tcnt_reg <= tx_ctrl_reg[`CT_SHORT_ECHO_TONE_BIT] ? ECHO_SHORT_CYC - 1 : ECHO_LONG_CYC - 1;
      else if (tstate_next == TS_OFF && tstate_reg == TS_DATA)
        tcnt_reg <= TURNOFF_CYC;
      else if (tcnt_reg != 32'h0)
        tcnt_reg <= tcnt_reg - 32'h1;
      tx_active_o <= tstate_next != TS_IDLE;
      echo_tone_o <= tstate_next == TS_ECHO;

      // transmit bit: parallel byte or synchronised serial pin
      if (tstate_reg == TS_DATA && tick) begin
        if (parallel) begin
          if (bitpos_reg == 3'h0) begin
            shift_reg     <= tx_buffer_avail_reg ? 8'hff : tx_data_reg;
            byte_full_reg <= ~tx_buffer_avail_reg;
            tx_bit_o      <= tx_buffer_avail_reg ? 1'b1 : tx_data_reg[0];
          end else
            tx_bit_o <= byte_full_reg ? shift_reg[bitpos_reg] : 1'b1;
          bitpos_reg <= bitpos_reg + 3'h1;
        end else
          tx_bit_o <= txd_sync_reg[1];
      end else if (tstate_reg != TS_DATA) begin
        tx_bit_o   <= 1'b1;
        bitpos_reg <= 3'h0;
      end

      // train on data
      if (tod_reg && eq_quality_poor_i) begin
        if (tod_cnt_reg == TOD_CYC - 1) begin
          retrain_o   <= 1'b1;
          tod_cnt_reg <= 32'h0;
        end else begin
          retrain_o   <= 1'b0;
          tod_cnt_reg <= tod_cnt_reg + 32'h1;
        end
      end else begin
        retrain_o   <= 1'b0;
        tod_cnt_reg <= 32'h0;
      end
    end
  end
endmodule // modem_host_mem

// ### hdl/modem_host_consts.vh
// Purpose: constants for the modem host interface memory
// Assumes: byte address = 4 * (bank * 16 + register index)
// Notes:   bank 0 transmitter, bank 1 sample receiver, bank 2 baud receiver
`ifndef MODEM_HOST_CONSTS_VH
`define MODEM_HOST_CONSTS_VH
`define BANK_TX            2'h0
`define BANK_RXS           2'h1
`define BANK_RXB           2'h2
`define REG_DATA0          4'h0
`define REG_DATA1          4'h1
`define REG_DATA2          4'h2
`define REG_DATA3          4'h3
`define REG_ACC_Y          4'h4
`define REG_ACC_X          4'h5
`define REG_CONFIG         4'h6
`define REG_CTRL           4'h7
`define REG_STATUS         4'he
`define ST_AVAIL_BIT       0
`define ST_IE_BIT          2
`define ST_SETUP_BIT       3
`define ST_IA_BIT          7
`define CT_SHORT_ECHO_TONE_BIT        0
`define CT_EXT_TX_CLOCK_SELECT_BIT        1
`define CT_TX_PARALLEL_MODE_BIT        2
`define CT_RTS_BIT         7
`define CR_T2_BIT          1
`define CR_RX_PARALLEL_MODE_BIT        4
`define CF_TOD_BIT         6
`define TX_CFG_RESET       8'h14
`define RX_CFG_RESET       6'h14
`define RX_CTRL_RESET      8'h02
`define TX_CTRL_RESET      8'h00
`define CFG_9600           6'h14
`define CFG_7200           6'h12
`define CFG_4800           6'h11
`define CFG_4800L          6'h22
`define CFG_2400L          6'h21
`define CFG_4800S          6'h02
`define CFG_2400S          6'h01
`define CFG_TONE           8'h80
`define CLK_MHZ            200
`define ECHO_SHORT_MS      30
`define ECHO_LONG_MS       185
`define TOD_MS             500
`define READY_MS           10
`define TURNOFF_MS         5
`define CYC_PER_MS         (`CLK_MHZ * 1000)
`endif

// ### verif/modem_host_checker.sv
// Purpose: port assertions for the modem host interface memory
// Assumes: one clock, synchronous active high reset
// Notes:   bound into every instance of the design
`timescale 1ns/1ps
module modem_host_checker #(
  parameter READY_CYC     = 10,
  parameter ECHO_LONG_CYC = 40
) (
  // clock and reset
  input wire       clk_i,
  input wire       sys_rst_i,
  // bus
  input wire       avs_read_i,
  input wire       avs_write_i,
  input wire       avs_waitrequest_o,
  // core side
  input wire       eq_quality_poor_i,
  input wire       rts_pin_i,
  // outputs
  input wire       irq_n_o,
  input wire       tx_active_o,
  input wire       tx_bit_o,
  input wire       echo_tone_o,
  input wire       retrain_o,
  input wire       ready_o,
  input wire [7:0] tx_cfg_o,
  input wire [5:0] rx_cfg_o
);
  integer up_cnt;
  integer tone_cnt;
  reg     wr_seen;
  // cycles since reset, tone length, first write seen
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      up_cnt   <= 0;
      tone_cnt <= 0;
      wr_seen  <= 1'b0;
    end else begin
      if (up_cnt < 100000)
        up_cnt <= up_cnt + 1;
      tone_cnt <= echo_tone_o ? tone_cnt + 1 : 0;
      if (avs_write_i)
        wr_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_wait_one_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_req_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |-> ##[1:2] !avs_waitrequest_o) else $error("bus request not answered");
  a_cfg_defaults: assert property ($fell(sys_rst_i) |-> tx_cfg_o == 8'h14 && rx_cfg_o == 6'h14)
    else $error("configuration not at defaults after reset");
  a_irq_default: assert property (!wr_seen |-> irq_n_o)
    else $error("interrupt low before any enable was written");
  a_ready_early: assert property (ready_o |-> up_cnt >= READY_CYC - 2)
    else $error("ready too early after reset");
  a_ready_late: assert property (up_cnt == READY_CYC + 4 |-> ready_o)
    else $error("ready too late after reset");
  a_rts_starts: assert property ((ready_o && rts_pin_i) [*8] |-> tx_active_o)
    else $error("request to send pin did not start transmission");
  a_start_ready: assert property ($rose(tx_active_o) |-> ready_o)
    else $error("transmission started before ready");
  a_idle_mark: assert property (!tx_active_o && !$past(tx_active_o) |-> tx_bit_o)
    else $error("transmit bit not idle while not transmitting");
  a_tone_length: assert property (tone_cnt <= ECHO_LONG_CYC)
    else $error("echo tone longer than standard length");
  a_retrain_pulse: assert property (retrain_o |=> !retrain_o)
    else $error("retrain pulse longer than one cycle");
  a_retrain_cause: assert property (retrain_o |-> $past(eq_quality_poor_i, 2))
    else $error("retrain without poor quality");
  c_tx_start: cover property ($rose(tx_active_o));
  c_irq_low: cover property (!irq_n_o);
  c_retrain: cover property (retrain_o);
  c_tone_end: cover property ($fell(echo_tone_o));
endmodule // modem_host_checker

bind modem_host_mem modem_host_checker #(.READY_CYC(READY_CYC), .ECHO_LONG_CYC(ECHO_LONG_CYC)) chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .eq_quality_poor_i(eq_quality_poor_i),
  .rts_pin_i(rts_pin_i), .irq_n_o(irq_n_o), .tx_active_o(tx_active_o), .tx_bit_o(tx_bit_o),
  .echo_tone_o(echo_tone_o), .retrain_o(retrain_o), .ready_o(ready_o),
  .tx_cfg_o(tx_cfg_o), .rx_cfg_o(rx_cfg_o));

// ### verif/modem_core_model.sv
// Purpose: modem core side model feeding the interface memory
// Assumes: words handed over as one-cycle pulses
// Notes:   ext clock stands still unless ticks are asked for
`timescale 1ns/1ps
module modem_core_model (
  // clock
  input  wire        clk_i,
  // core lines
  output reg         rx_valid_o,
  output reg  [15:0] rx_word_o,
  output reg         baud_valid_o,
  output reg  [15:0] baud_word_o,
  output reg         poor_o,
  output reg         rts_o,
  output reg         txd_o,
  output reg         ext_clk_o
);
  initial begin
    {rx_valid_o, baud_valid_o, poor_o, rts_o, txd_o, ext_clk_o} = 6'h00;
    rx_word_o   = 16'h0000;
    baud_word_o = 16'h0000;
  end
  // serial data changes every cycle
  always @(posedge clk_i)
    txd_o <= ~txd_o;
  // receiver writes a new word, then the word lines move on
  task push_word(input sel, input [15:0] w);
    begin
      @(posedge clk_i);
      if (sel) begin
        baud_word_o  <= w;
        baud_valid_o <= 1'b1;
      end else begin
        rx_word_o  <= w;
        rx_valid_o <= 1'b1;
      end
      @(posedge clk_i);
      rx_valid_o   <= 1'b0;
      baud_valid_o <= 1'b0;
      rx_word_o    <= ~rx_word_o;
      baud_word_o  <= ~baud_word_o;
    end
  endtask
  task set_lines(input rts, input poor);
    begin
      @(posedge clk_i);
      rts_o  <= rts;
      poor_o <= poor;
    end
  endtask
  // slow external transmit clock, wide enough for the synchronizer
  task ext_ticks(input integer n);
    begin
      repeat (n) begin
        repeat (3) @(posedge clk_i);
        ext_clk_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_clk_o <= 1'b0;
      end
    end
  endtask
endmodule // modem_core_model

// ### verif/modem_host_interface_memory_bench.sv
// Purpose: self-checking bench for the modem host interface memory
// Assumes: byte address is bank, index, two zero bits
// Notes:   long times shortened through parameters
`timescale 1ns/1ps
module modem_host_interface_memory_bench;
  reg         clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg  [7:0]  avs_address_i = 8'h00;
  reg         avs_read_i = 1'b0;
  reg         avs_write_i = 1'b0;
  reg  [31:0] avs_writedata_i = 32'h0;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, rxv, bdv, poor, rts, txd, xclk;
  wire [15:0] rxw, bdw;
  wire        irq_n_o, tx_active_o, tx_bit_o, echo_tone_o, rxd_serial_o, retrain_o, ready_o;
  wire [7:0]  tx_cfg_o;
  wire [5:0]  rx_cfg_o;
  integer     fail_count = 0;
  integer     comparisons = 0;
  integer     k, n, t;
  reg  [7:0]  rd;
  reg  [7:0]  codes [0:7];
  always #2.5 clk_i = ~clk_i;
  modem_core_model core (.clk_i(clk_i), .rx_valid_o(rxv), .rx_word_o(rxw), .baud_valid_o(bdv),
    .baud_word_o(bdw), .poor_o(poor), .rts_o(rts), .txd_o(txd), .ext_clk_o(xclk));
  modem_host_mem #(.ECHO_SHORT_CYC(20), .ECHO_LONG_CYC(40), .TOD_CYC(30), .READY_CYC(10),
    .TURNOFF_CYC(5)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_word_valid_i(rxv), .rx_word_i(rxw),
    .baud_word_valid_i(bdv), .baud_word_i(bdw), .eq_quality_poor_i(poor), .rts_pin_i(rts),
    .txd_pin_i(txd), .ext_tx_clk_i(xclk), .irq_n_o(irq_n_o), .tx_active_o(tx_active_o),
    .tx_bit_o(tx_bit_o), .echo_tone_o(echo_tone_o), .rxd_serial_o(rxd_serial_o),
    .retrain_o(retrain_o), .ready_o(ready_o), .tx_cfg_o(tx_cfg_o), .rx_cfg_o(rx_cfg_o));
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tmo;
    begin
      fail_count = fail_count + 1;
      $display("BAD wait expected done seen timeout");
      test_done;
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task bus(input wr, input [1:0] b, input [3:0] i, input [7:0] d);
    begin
      avs_address_i   <= {b, i, 2'b00};
      avs_writedata_i <= {24'h0, d};
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      t = 0;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0 && t < 50) begin
        @(posedge clk_i);
        t = t + 1;
      end
      rd = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge clk_i);
      if (t >= 50)
        tmo;
    end
  endtask
  task expect_reg(input [1:0] b, input [3:0] i, input [7:0] exp);
    begin
      bus(1'b0, b, i, 8'h00);
      check("register", rd, exp);
    end
  endtask
  task wait_status(input [1:0] b, input integer bitn, input v);
    begin
      n = 0;
      do begin
        bus(1'b0, b, 4'he, 8'h00);
        n = n + 1;
      end while (rd[bitn] !== v && n < 100);
      if (n >= 100)
        tmo;
    end
  endtask
  function port_val(input [2:0] s);
    case (s)
      3'h0: port_val = ready_o;
      3'h1: port_val = echo_tone_o;
      3'h2: port_val = tx_active_o;
      default: port_val = retrain_o;
    endcase
  endfunction
  task wait_port(input [2:0] s, input v);
    begin
      n = 0;
      while (port_val(s) !== v && n < 2000) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n >= 2000)
        tmo;
    end
  endtask
  task do_reset;
    begin
      sys_rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task chk_defaults;
    begin
      check("tx_cfg", tx_cfg_o, 8'h14);
      check("rx_cfg", {2'b00, rx_cfg_o}, 8'h14);
      check("irq_n", {7'h0, irq_n_o}, 8'h01);
      check("rxd", {7'h0, rxd_serial_o}, 8'h01);
      expect_reg(2'h1, 4'h6, 8'h14);
      expect_reg(2'h1, 4'h7, 8'h02);
      expect_reg(2'h0, 4'h7, 8'h00);
      expect_reg(2'h0, 4'hf, 8'h00);
    end
  endtask
  initial begin
    {codes[0], codes[1], codes[2], codes[3]} = {8'h14, 8'h12, 8'h11, 8'h22};
    {codes[4], codes[5], codes[6], codes[7]} = {8'h21, 8'h02, 8'h01, 8'h80};
    do_reset;
    chk_defaults;
    wait_port(3'h0, 1'b1);
    for (k = 6; k >= 0; k = k - 1) begin
      bus(1'b1, 2'h1, 4'h6, codes[k]);
      bus(1'b1, 2'h1, 4'he, 8'h08);
      wait_status(2'h1, 3, 1'b0);
      check("rx_cfg", {2'b00, rx_cfg_o}, {2'b00, codes[k][5:0]});
    end
    for (k = 7; k >= 0; k = k - 1) begin
      bus(1'b1, 2'h0, 4'h6, codes[k]);
      bus(1'b1, 2'h0, 4'he, 8'h08);
      wait_status(2'h0, 3, 1'b0);
      check("tx_cfg", tx_cfg_o, codes[k]);
    end
    bus(1'b1, 2'h1, 4'h7, 8'h12);
    core.push_word(1'b0, 16'hbeef);
    expect_reg(2'h1, 4'he, 8'h01);
    bus(1'b1, 2'h1, 4'he, 8'h04);
    check("irq_n", {7'h0, irq_n_o}, 8'h00);
    expect_reg(2'h1, 4'he, 8'h85);
    expect_reg(2'h1, 4'h0, 8'hef);
    expect_reg(2'h1, 4'he, 8'h04);
    expect_reg(2'h1, 4'h1, 8'hbe);
    check("irq_n", {7'h0, irq_n_o}, 8'h01);
    bus(1'b1, 2'h1, 4'he, 8'h00);
    bus(1'b1, 2'h2, 4'he, 8'h04);
    core.push_word(1'b1, 16'h1234);
    @(posedge clk_i);
    expect_reg(2'h2, 4'he, 8'h85);
    check("irq_n", {7'h0, irq_n_o}, 8'h00);
    expect_reg(2'h2, 4'h0, 8'h34);
    expect_reg(2'h2, 4'he, 8'h04);
    check("irq_n", {7'h0, irq_n_o}, 8'h01);
    bus(1'b1, 2'h2, 4'he, 8'h00);
    for (k = 1; k >= 0; k = k - 1) begin
      bus(1'b1, 2'h0, 4'h7, k ? 8'h87 : 8'h80);
      wait_port(3'h1, 1'b1);
      t = 0;
      while (echo_tone_o === 1'b1 && t < 200) begin
        @(posedge clk_i);
        t = t + 1;
      end
      check("tone_len", t[7:0], k ? 8'h14 : 8'h28);
      if (k) begin
        bus(1'b1, 2'h0, 4'h0, 8'ha5);
        expect_reg(2'h0, 4'he, 8'h00);
        bus(1'b1, 2'h0, 4'he, 8'h04);
        repeat (40) @(posedge clk_i);
        check("irq_n", {7'h0, irq_n_o}, 8'h01);
        expect_reg(2'h0, 4'he, 8'h04);
        for (n = 0; n < 8; n = n + 1) begin
          core.ext_ticks(1);
          @(posedge clk_i);
          check("tx_bit", {7'h0, tx_bit_o}, (8'ha5 >> n) & 8'h01);
        end
        wait_status(2'h0, 0, 1'b1);
        check("irq_n", {7'h0, irq_n_o}, 8'h00);
        expect_reg(2'h0, 4'he, 8'h85);
        bus(1'b1, 2'h0, 4'he, 8'h00);
      end
      bus(1'b1, 2'h0, 4'h7, 8'h00);
      wait_port(3'h2, 1'b0);
    end
    core.set_lines(1'b1, 1'b0);
    wait_port(3'h2, 1'b1);
    core.set_lines(1'b0, 1'b1);
    wait_port(3'h2, 1'b0);
    t = 0;
    repeat (80) begin
      @(posedge clk_i);
      t = t + (retrain_o === 1'b1);
    end
    check("retrain_off", t[7:0], 8'h00);
    bus(1'b1, 2'h1, 4'h6, 8'h54);
    wait_port(3'h4, 1'b1);
    core.set_lines(1'b0, 1'b0);
    do_reset;
    chk_defaults;
    bus(1'b1, 2'h0, 4'h7, 8'h02);
    core.push_word(1'b0, 16'h00b4);
    for (n = 0; n < 8; n = n + 1) begin
      core.ext_ticks(1);
      @(posedge clk_i);
      check("rxd", {7'h0, rxd_serial_o}, (8'hb4 >> n) & 8'h01);
    end
    test_done;
  end
endmodule // modem_host_interface_memory_bench
